// *** ccv_pkg.sv ***
package ccv_pkg;
  localparam int CCV_COMP_W_DEF   = 8;   // bits per colour component
  localparam int CCV_BYTE_W       = 8;   // stream words are whole bytes
  localparam int CCV_BASE_LAT     = 9;   // pipeline depth before the optional clip and clamp stages
  localparam int CCV_INTC_W       = 6;   // interrupt controller bus width
  localparam int CCV_SOF_BIT      = 0;   // start-of-frame position in user sideband
  localparam int CCV_RST_MIN_CYC  = 32;  // least reset hold, other party's duty

  // padded width of a word of three components
  function automatic int ccv_word_w(input int comp_w);
    return ((3 * comp_w + CCV_BYTE_W - 1) / CCV_BYTE_W) * CCV_BYTE_W;
  endfunction
endpackage : ccv_pkg

// *** ccv_stage.sv ***
`timescale 1ns/1ps
// one pipeline stage carrying a pixel and its flags, with its own valid bit
module ccv_stage
  import ccv_pkg::*;
#(
  parameter int W = 26
)(
  input  wire logic         clk,     // core clock
  input  wire logic         rst_n,   // synchronous reset, active low
  input  wire logic         adv,     // advance enable
  input  wire logic         vld_i,   // upstream stage holds a pixel
  input  wire logic [W-1:0] dat_i,   // upstream data and flags
  output logic              vld_o,   // this stage holds a pixel
  output logic      [W-1:0] dat_o    // this stage's data and flags
);
  logic         vld_d;
  logic [W-1:0] dat_d;

  always_comb
  begin
    vld_d = vld_o;
    dat_d = dat_o;
    if (adv)
    begin
      vld_d = vld_i;
      dat_d = dat_i;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      vld_o <= 1'b0;
      dat_o <= '0;
    end
    else
    begin
      vld_o <= vld_d;
      dat_o <= dat_d;
    end
  end
endmodule // ccv_stage

// *** ccv_stream_port.sv ***
`timescale 1ns/1ps
module ccv_stream_port
  import ccv_pkg::*;
#(
  parameter int COMP_W    = CCV_COMP_W_DEF, // bits per component
  parameter bit HAS_CLIP  = 1'b1,           // clipping stage present
  parameter bit HAS_CLAMP = 1'b1,           // clamping stage present
  parameter bit HAS_INTC  = 1'b0,           // interrupt controller bus present
  parameter int DW        = ccv_word_w(COMP_W)
)(
  input  wire logic                  clk,              // core clock
  input  wire logic                  clk_en,           // core clock enable, active high
  input  wire logic                  rst_n,            // synchronous reset, active low
  input  wire logic [DW-1:0]         s_axis_video_tdata,  // input pixel
  input  wire logic                  s_axis_video_tvalid, // input valid
  output logic                       s_axis_video_tready, // input ready
  input  wire logic                  s_axis_video_tuser,  // input start of frame
  input  wire logic                  s_axis_video_tlast,  // input end of line
  output logic [DW-1:0]              m_axis_video_tdata,  // output pixel
  output logic                       m_axis_video_tvalid, // output valid
  input  wire logic                  m_axis_video_tready, // output ready
  output logic                       m_axis_video_tuser,  // output start of frame
  output logic                       m_axis_video_tlast,  // output end of line
  output logic [CCV_INTC_W-1:0]      interrupt_controller_bus // interrupt bus
);
  // ----------------------------------------------------------------
  // pipeline sizing
  // ----------------------------------------------------------------
  localparam int LAT = CCV_BASE_LAT + int'(HAS_CLIP) + int'(HAS_CLAMP);
  localparam int PW  = 3 * COMP_W;
  localparam int SW  = PW + 2; // pixel plus end-of-line and start-of-frame

  // stages run in lock step; a stall freezes the whole pipe
  logic          adv;
  logic [LAT:0]  vld;
  logic [SW-1:0] dat [LAT+1];

  // ----------------------------------------------------------------
  // flow control
  // ----------------------------------------------------------------
  // pipe moves when enabled and the output slot is empty or taken
  always_comb
  begin
    adv = clk_en && (!vld[LAT] || m_axis_video_tready);
  end

  // ----------------------------------------------------------------
  // input skid slot
  // ----------------------------------------------------------------
  // ready leaves a flop and cannot see this cycle's stall; a pixel taken
  // while the pipe stands waits here and enters on the next advance, so no bubble follows a stall
  logic          skid_vld_q;
  logic          skid_vld_d;
  logic [SW-1:0] skid_dat_q;
  logic [SW-1:0] skid_dat_d;
  logic          rdy_q;
  logic          rdy_d;
  logic          take;
  logic [SW-1:0] in_word;

  // only the low components of the padded word are used
  always_comb
  begin
    in_word = {s_axis_video_tuser, s_axis_video_tlast,
               s_axis_video_tdata[PW-1:0]};
    take    = clk_en && rdy_q && s_axis_video_tvalid;
  end

  always_comb
  begin
    skid_vld_d = skid_vld_q;
    skid_dat_d = skid_dat_q;
    if (skid_vld_q && adv)
      skid_vld_d = 1'b0;
    else if (!skid_vld_q && take && !adv)
    begin
      skid_vld_d = 1'b1;
      skid_dat_d = in_word;
    end
    // enable low holds ready at its level, as every other output
    rdy_d = clk_en ? !skid_vld_d : rdy_q;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      skid_vld_q <= 1'b0;
      skid_dat_q <= '0;
      rdy_q      <= 1'b0;
    end
    else
    begin
      skid_vld_q <= skid_vld_d;
      skid_dat_q <= skid_dat_d;
      rdy_q      <= rdy_d;
    end
  end

  // a waiting pixel enters first, so order survives a stall
  assign vld[0] = skid_vld_q || take;
  assign dat[0] = skid_vld_q ? skid_dat_q : in_word;

  for (genvar g = 0; g < LAT; g++)
  begin : g_pipe
    ccv_stage #(.W(SW)) u_stage (
      .clk   (clk),
      .rst_n (rst_n),
      .adv   (adv),
      .vld_i (vld[g]),
      .dat_i (dat[g]),
      .vld_o (vld[g+1]),
      .dat_o (dat[g+1])
    );
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  // ready is the only stream output made here; the rest leave the last stage
  assign s_axis_video_tready = rdy_q;

  assign m_axis_video_tvalid = vld[LAT];
  assign m_axis_video_tlast  = dat[LAT][PW];
  assign m_axis_video_tuser  = dat[LAT][PW+1];
  assign m_axis_video_tdata  = DW'(dat[LAT][PW-1:0]);

  // ----------------------------------------------------------------
  // optional interrupt controller bus
  // ----------------------------------------------------------------
  // no interrupt sources live in this block; the bus idles at zero
  logic [CCV_INTC_W-1:0] intc_q;
  logic [CCV_INTC_W-1:0] intc_d;

  always_comb
  begin
    intc_d = '0;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      intc_q <= '0;
    else
      intc_q <= intc_d;
  end
  assign interrupt_controller_bus = HAS_INTC ? intc_q : '0;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  hold_on_stall_a: assert property (@(posedge clk) disable iff (!rst_n)
    m_axis_video_tvalid && !m_axis_video_tready |=>
      $stable(m_axis_video_tdata) && $stable(m_axis_video_tuser) && m_axis_video_tvalid)
    else $error("output changed while stalled");
  enable_freeze_a: assert property (@(posedge clk) disable iff (!rst_n)
    !clk_en |=> $stable(vld[LAT:1]) && $stable(skid_vld_q) && $stable(m_axis_video_tlast))
    else $error("state moved with enable low");
  no_take_disabled_a: assert property (@(posedge clk) disable iff (!rst_n)
    !clk_en |=> $stable(s_axis_video_tready) && $stable(vld[1]))
    else $error("input taken with enable low");
  reset_clears_a: assert property (@(posedge clk)
    !rst_n |=> !m_axis_video_tvalid)
    else $error("reset did not clear output valid");
  pipe_latency_a: assert property (@(posedge clk) disable iff (!rst_n)
    (s_axis_video_tvalid && s_axis_video_tready && m_axis_video_tready && clk_en)[*8]
      ##1 (m_axis_video_tready && clk_en)[*8] |-> m_axis_video_tvalid)
    else $error("pipeline did not deliver");
  flag_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
    (adv && vld[LAT-1]) |=> m_axis_video_tuser == $past(dat[LAT-1][PW+1]))
    else $error("start flag left its pixel");
  throughput_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && m_axis_video_tready && s_axis_video_tready |=> s_axis_video_tready)
    else $error("stall without back pressure");
  pad_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    m_axis_video_tvalid |-> (m_axis_video_tdata >> PW) == '0)
    else $error("padding bits not zero");
  eol_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
    (adv && vld[LAT-1]) |=> m_axis_video_tlast == $past(dat[LAT-1][PW]))
    else $error("end-of-line flag left its pixel");
  data_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
    (adv && vld[LAT-1]) |=> m_axis_video_tdata[PW-1:0] == $past(dat[LAT-1][PW-1:0]))
    else $error("pixel data changed in the pipe");

  // skid slot
  skid_block_a: assert property (@(posedge clk) disable iff (!rst_n)
    skid_vld_q |-> !s_axis_video_tready)
    else $error("ready high with a pixel waiting");
  skid_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    skid_vld_q && !adv |=> skid_vld_q && $stable(skid_dat_q))
    else $error("waiting pixel lost");
  skid_drain_a: assert property (@(posedge clk) disable iff (!rst_n)
    skid_vld_q && adv |=> vld[1] && dat[1] == $past(skid_dat_q))
    else $error("waiting pixel not passed on");
  reset_ready_a: assert property (@(posedge clk)
    !rst_n |=> !s_axis_video_tready && !skid_vld_q)
    else $error("reset did not clear ready");

  // interrupt bus
  intc_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
    interrupt_controller_bus == '0)
    else $error("interrupt bus not idle");
endmodule // ccv_stream_port

// *** ccv_sink_model.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// downstream sink
// ----------------------------------------
module ccv_sink_model (
  input  wire logic clk,   // core clock
  input  wire logic stall, // bench request to hold ready low
  output logic      ready  // sink ready
);
  // ready is registered and ignores valid, so it never combines back into the port
  always_ff @(posedge clk)
    ready <= !stall;
endmodule // ccv_sink_model

// *** color_convert_video_stream_port_tb.sv ***
`timescale 1ns/1ps
module color_convert_video_stream_port_tb;
  import ccv_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        clk_en = 1'b1;
  logic        stall = 1'b0;
  logic [31:0] sd = 32'h0;
  logic        sv = 1'b0;
  logic        su = 1'b0;
  logic        sl = 1'b0;
  logic        sr, mv, mu, ml, rdy;
  logic [31:0] md;
  logic [CCV_INTC_W-1:0] irq;
  int          error_cnt = 0;
  int          check_count = 0;
  int          cyc = 0;
  // ----------------------------------------
  // clock, sink and design
  // ----------------------------------------
  always #5 clk = ~clk;
  ccv_sink_model sink_u (.clk(clk), .stall(stall), .ready(rdy));
  ccv_stream_port #(.COMP_W(10)) dut_u (
    .clk(clk), .clk_en(clk_en), .rst_n(rst_n),
    .s_axis_video_tdata(sd), .s_axis_video_tvalid(sv), .s_axis_video_tready(sr),
    .s_axis_video_tuser(su), .s_axis_video_tlast(sl),
    .m_axis_video_tdata(md), .m_axis_video_tvalid(mv), .m_axis_video_tready(rdy),
    .m_axis_video_tuser(mu), .m_axis_video_tlast(ml), .interrupt_controller_bus(irq));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 1000)
    begin
      error_cnt++;
      print_verdict();
    end
  end
  task automatic chk(input logic ok, input string m);
    check_count++;
    if (ok !== 1'b1)
    begin
      error_cnt++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask
  // valid stays up until an edge sees ready, so back-to-back calls stream
  task automatic push(input logic [31:0] d, input logic u, input logic l);
    sd <= d;
    su <= u;
    sl <= l;
    sv <= 1'b1;
    do @(posedge clk); while (sr !== 1'b1 || clk_en !== 1'b1);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_lat();
    push(32'h3ABC_DE12, 1'b1, 1'b1);
    sv <= 1'b0;
    repeat (9) @(posedge clk);
    #1 chk(mv === 1'b0, "output too early");
    @(posedge clk);
    #1 chk(mv === 1'b1 && md === 32'h3ABC_DE12, "latency or data");
    chk(mu === 1'b1 && ml === 1'b1, "flags lost");
    chk(irq === '0, "interrupt bus not idle");
    $display("latency test done");
  endtask
  task automatic t_freeze();
    stall <= 1'b1;
    push(32'h1555_0AAA, 1'b0, 1'b1);
    sv <= 1'b0;
    repeat (14) @(posedge clk);
    push(32'h0222_0333, 1'b0, 1'b0);
    sv <= 1'b0;
    clk_en <= 1'b0;
    stall <= 1'b0;
    repeat (4) @(posedge clk);
    #1 chk(sr === 1'b0, "ready while disabled");
    chk(mv === 1'b1 && md === 32'h1555_0AAA && ml === 1'b1, "output moved");
    clk_en <= 1'b1;
    @(posedge clk);
    clk_en <= 1'b0;
    $display("freeze test done");
  endtask
  task automatic t_rst();
    @(posedge clk) rst_n <= 1'b0;
    @(posedge clk);
    #1 chk(mv === 1'b0, "reset ignored while disabled");
    repeat (32) @(posedge clk);
    rst_n <= 1'b1;
    clk_en <= 1'b1;
    @(posedge clk);
    $display("reset test done");
  endtask
  task automatic t_stream();
    su <= 1'b1;
    @(posedge clk);
    for (int k = 0; k < 8; k++)
      push(32'h0000_0100 + k, k == 0, k == 7);
    sv <= 1'b0;
    for (int i = 0; i < 20 && mv !== 1'b1; i++)
      @(posedge clk) #1;
    for (int k = 0; k < 8; k++)
    begin
      chk(mv === 1'b1 && md === 32'h0000_0100 + k, "gap or data");
      chk(mu === (k == 0) && ml === (k == 7), "flag misplaced");
      @(posedge clk) #1;
    end
    chk(mv === 1'b0, "extra pixel");
    $display("stream test done");
  endtask
  initial
  begin
    repeat (32) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_lat();
    t_freeze();
    t_rst();
    t_stream();
    print_verdict();
  end
endmodule // color_convert_video_stream_port_tb
